// ===== dhi_host_model.sv
`timescale 1ns/1ps
`default_nettype none

// host microcontroller model: parallel strobes, spi frames and i2c master
module dhi_host (
	input wire logic clk,
	input wire logic [7:0] bus,
	output logic cs_n,
	output logic dc,
	output logic rw,
	output logic en,
	output logic [7:0] d
);

	// idle pins at time zero; strobes are parked per port by park
	initial begin
		cs_n = 1'b1;
		dc = 1'b0;
		rw = 1'b0;
		en = 1'b0;
		d = 8'h00;
	end

	////////////////////////////////////////
	// strobe levels differ per port, so park them before the first access
	task automatic park(input logic [2:0] m);
		@(posedge clk);
		rw <= (m == 3'h6);
		en <= (m == 3'h6);
		dc <= (m == 3'h2);
		d <= (m == 3'h2) ? 8'h03 : 8'h00;
		cs_n <= 1'b1;
	endtask

	// one parallel access; q is the bus seen while the strobe is active
	task automatic par(input int m, input logic csv, input logic rd, input logic dcv,
			input logic [7:0] v, output logic [7:0] q);
		@(posedge clk);
		cs_n <= csv;
		dc <= dcv;
		d <= v;
		rw <= (m == 4) ? rd : 1'b1;
		en <= (m != 4);
		// setup of four cycles before the strobe phase
		repeat (4) @(posedge clk);
		if (m == 4) en <= 1'b1;
		else if (rd) en <= 1'b0;
		else rw <= 1'b0;
		repeat (8) @(posedge clk);
		q = bus;
		if (m == 4) en <= 1'b0;
		else begin
			en <= 1'b1;
			rw <= 1'b1;
		end
		repeat (6) @(posedge clk);
		cs_n <= 1'b1;
		d <= ~v; // released bus shows a changed value
	endtask

	////////////////////////////////////////
	// serial frame of n bits, msb first; sclk rests low outside frames
	task automatic spi(input int n, input logic dcv, input logic [8:0] v);
		@(posedge clk);
		#7;
		cs_n <= 1'b0;
		dc <= dcv;
		for (int i = n - 1; i >= 0; i--) begin
			d[1] <= v[i];
			#80 d[0] <= 1'b1;
			#80 d[0] <= 1'b0;
		end
		#80 cs_n <= 1'b1;
		d[1] <= ~d[1];
	endtask

	////////////////////////////////////////
	// one scl pulse; data only moves while scl is low
	task automatic i2c_bit(input logic b, output logic s);
		#80 d[1] <= b;
		#80 d[0] <= 1'b1;
		#80 s = bus[1];
		#80 d[0] <= 1'b0;
	endtask

	// eight bits then a released ninth bit; the out pin is wired, so ack is real
	task automatic i2c_byte(input logic [7:0] v, output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--) i2c_bit(v[i], s);
		i2c_bit(1'b1, s);
		ack = ~s;
	endtask

	// start from idle-high lines, or stop from scl low
	task automatic i2c_ss(input logic start);
		if (start) begin
			#80 d[1] <= 1'b0;
			#80 d[0] <= 1'b0;
		end else begin
			#80 d[1] <= 1'b0;
			#80 d[0] <= 1'b1;
			#80 d[1] <= 1'b1;
		end
	endtask

endmodule

`default_nettype wire

// ===== dhi_params.svh
`ifndef DHI_PARAMS_SVH
`define DHI_PARAMS_SVH

// interface select pin codes
`define DHI_SEL_SPI4 3'h0
`define DHI_SEL_SPI3 3'h1
`define DHI_SEL_I2C 3'h2
`define DHI_SEL_P6800 3'h4
`define DHI_SEL_P8080 3'h6
`define DHI_SEL_OFF 3'h7

// i2c target address, upper six bits; the lowest comes from the pin
`define DHI_I2C_ADDR_HI 6'h1e
`define DHI_I2C_ACK_CNT 4'h8
`define DHI_SDA_OUT_BIT 2
`define DHI_SCL_BIT 0
`define DHI_SDA_IN_BIT 1

// serial byte framing: index of the last clock of a byte
`define DHI_SPI4_LAST 4'h7
`define DHI_SPI3_LAST 4'h8

// reset values
`define DHI_PIN_RST 17'h1f000
`define DHI_COL_RST 8'h00

`endif

// ===== dhi_pkg.sv
`include "dhi_params.svh"

package dhi_pkg;

	// host port in use
	typedef enum logic [2:0] {
		MODE_SPI4 = `DHI_SEL_SPI4,
		MODE_SPI3 = `DHI_SEL_SPI3,
		MODE_I2C = `DHI_SEL_I2C,
		MODE_P6800 = `DHI_SEL_P6800,
		MODE_P8080 = `DHI_SEL_P8080,
		MODE_OFF = `DHI_SEL_OFF
	} dhi_mode_t;

	// i2c target states, gray along idle-addr-ctrl-data
	typedef enum logic [2:0] {
		I2C_IDLE = 3'h0,
		I2C_ADDR = 3'h1,
		I2C_CTRL = 3'h3,
		I2C_DATA = 3'h2,
		I2C_RDIGN = 3'h6
	} dhi_i2c_st_t;

	// pins as seen after the synchroniser
	typedef struct packed {
		logic [2:0] sel;
		logic hw_rst_n;
		logic cs_n;
		logic dc;
		logic rw;
		logic en;
		logic spi_tog;
		logic [7:0] d;
	} dhi_pins_t;

	// one byte toward the command decoder or display ram
	typedef struct packed {
		logic is_data;
		logic [7:0] byte_v;
	} dhi_wr_t;

endpackage

// ===== dhi_spi_rx.sv
`timescale 1ns/1ps
`default_nettype none
`include "dhi_params.svh"

// serial receiver on the host clock; bytes leave by a toggle
module dhi_spi_rx (
	input wire logic spi_sclk,
	input wire logic hardware_reset_n,
	input wire logic cs_n,
	input wire logic three_wire,
	input wire logic serial_input_pin,
	input wire logic dc_pin,
	output logic [7:0] rx_byte,
	output logic rx_dc,
	output logic rx_tog
);

	typedef struct packed {
		logic [6:0] sr;
		logic [3:0] cnt;
		logic dc_lead;
	} dhi_frm_t;

	typedef struct packed {
		logic [7:0] byte_v;
		logic dc;
		logic tog;
	} dhi_out_t;

	dhi_frm_t fq, fn;
	dhi_out_t oq, on;
	logic frame_clr;
	logic [3:0] last;

	// the clock stands still outside frames, so the frame is ended by chip select
	assign frame_clr = cs_n | ~hardware_reset_n;
	assign last = three_wire ? `DHI_SPI3_LAST : `DHI_SPI4_LAST;

	// shift msb first; leading bit in three-wire mode is the data/command flag
	always_comb begin
		fn = fq;
		on = oq;
		if (three_wire && fq.cnt == 4'h0) begin
			fn.dc_lead = serial_input_pin;
		end else begin
			fn.sr = {fq.sr[5:0], serial_input_pin};
		end
		if (fq.cnt == last) begin
			on.byte_v = {fq.sr, serial_input_pin};
			on.dc = three_wire ? fq.dc_lead : dc_pin;
			on.tog = ~oq.tog;
			fn.cnt = 4'h0;
		end else begin
			fn.cnt = fq.cnt + 4'h1;
		end
	end

	// framing state is cleared whenever chip select rises
	always_ff @(posedge spi_sclk or posedge frame_clr) begin
		if (frame_clr) begin
			fq <= '0;
		end else begin
			fq <= fn;
		end
	end

	// held past chip select so the far domain can still read the last byte
	always_ff @(posedge spi_sclk or negedge hardware_reset_n) begin
		if (!hardware_reset_n) begin
			oq <= '0;
		end else begin
			oq <= on;
		end
	end

	assign rx_byte = oq.byte_v;
	assign rx_dc = oq.dc;
	assign rx_tog = oq.tog;

endmodule

`default_nettype wire

// ===== dhi_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "dhi_params.svh"

// What this block does
// - Host port chosen from three select pins: spi4, spi3, i2c, two parallel kinds.
// - Enable-strobe port: read/write pin low writes; data/command low means command.
// - Enable-strobe port captures on enable falling edge, only with chip select low.
// - Strobe-pair port: read strobe rising ends a read, chip select low, write high.
// - Strobe-pair port: write strobe rising latches byte, chip select low, read high.
// - Four-wire serial shifts input on rising clock into eight bits, msb first.
// - Four-wire data/command pin sampled on eighth clock; host keeps it steady.
// - Completed serial byte goes to ram if flag high, else command register.
// - Serial modes are write only; no read path.
// - Three-wire frames are nine bits: data/command flag, then eight bits msb first.
// - I2c target answers 0111100 or 0111101, chosen by the address select pin.
// - Address read/write bit one is read mode, zero is write mode.
// - Data falling while clock high is start; address byte follows.
// - A matching address and each byte of a write are acknowledged by holding data low on ninth clock.
// - Control byte: continuation flag, data/command flag, six zeros.
// - Bytes after a control byte go to command or ram by its flag.
// - Column pointer steps by one after each display byte over i2c.
// - Data rising while clock high is stop; the write ends.
// - Hardware reset low clears the serial shift register and port state.
module dhi_top #(
	parameter int COL_W = 8
) (
	input wire logic clk,
	input wire logic srst,
	input wire logic hardware_reset_n,
	input wire logic [2:0] interface_select_pins,
	input wire logic cs_n,
	input wire logic dc_sel,
	input wire logic rw_sel,
	input wire logic en_sel,
	input wire logic [7:0] data_in,
	input wire logic spi_sclk,
	output logic [7:0] data_out,
	output logic [7:0] data_oe,
	input wire logic [7:0] status_in,
	input wire logic [7:0] rd_data,
	output logic wr_valid,
	output dhi_pkg::dhi_wr_t wr,
	output logic rd_req,
	output logic rd_is_data,
	output logic [COL_W-1:0] col_addr,
	output dhi_pkg::dhi_mode_t mode
);

	typedef struct packed {
		dhi_pkg::dhi_pins_t s1;
		dhi_pkg::dhi_pins_t s2;
		dhi_pkg::dhi_pins_t s3;
		dhi_pkg::dhi_pins_t stb;
		dhi_pkg::dhi_pins_t prv;
		dhi_pkg::dhi_mode_t mode;
		dhi_pkg::dhi_i2c_st_t i2c_st;
		logic [7:0] i2c_sr;
		logic [3:0] bitcnt;
		logic in_ack;
		logic ack_drv;
		logic cont;
		logic dcflag;
		logic wr_valid;
		dhi_pkg::dhi_wr_t wr;
		logic rd_req;
		logic rd_is_data;
		logic [7:0] rd_hold;
		logic [7:0] dout;
		logic [7:0] doe;
		logic [COL_W-1:0] col;
	} dhi_state_t;

	dhi_state_t q, n;
	dhi_pkg::dhi_pins_t pins_raw;
	logic [7:0] spi_byte;
	logic spi_dc;
	logic spi_tog;
	logic en_fall, en_rise, rw_rise, spi_evt;
	logic scl, sda, scl_rise, scl_fall, i2c_start, i2c_stop, addr_hit;

	////////////////////////////////////////////////////////////////////////
	// serial receiver on the host's clock

	dhi_spi_rx u_spi_rx (
		.spi_sclk(spi_sclk),
		.hardware_reset_n(hardware_reset_n),
		.cs_n(cs_n),
		.three_wire(interface_select_pins == `DHI_SEL_SPI3),
		.serial_input_pin(data_in[`DHI_SDA_IN_BIT]),
		.dc_pin(dc_sel),
		.rx_byte(spi_byte),
		.rx_dc(spi_dc),
		.rx_tog(spi_tog)
	);

	////////////////////////////////////////////////////////////////////////
	// pin bundle and edge terms on the settled copy

	// the receiver toggle rides the same synchroniser as the pins
	assign pins_raw = '{
		sel: interface_select_pins,
		hw_rst_n: hardware_reset_n,
		cs_n: cs_n,
		dc: dc_sel,
		rw: rw_sel,
		en: en_sel,
		spi_tog: spi_tog,
		d: data_in
	};

	assign en_fall = q.prv.en & ~q.stb.en;
	assign en_rise = ~q.prv.en & q.stb.en;
	assign rw_rise = ~q.prv.rw & q.stb.rw;
	assign spi_evt = q.prv.spi_tog ^ q.stb.spi_tog;
	assign scl = q.stb.d[`DHI_SCL_BIT];
	assign sda = q.stb.d[`DHI_SDA_IN_BIT];
	assign scl_rise = scl & ~q.prv.d[`DHI_SCL_BIT];
	assign scl_fall = ~scl & q.prv.d[`DHI_SCL_BIT];
	// host keeps data still while clock is high, so these are unambiguous
	assign i2c_start = scl & q.prv.d[`DHI_SCL_BIT] & q.prv.d[`DHI_SDA_IN_BIT] & ~sda;
	assign i2c_stop = scl & q.prv.d[`DHI_SCL_BIT] & ~q.prv.d[`DHI_SDA_IN_BIT] & sda;
	// address lsb follows the select pin
	assign addr_hit = (q.i2c_sr[7:2] == `DHI_I2C_ADDR_HI) && (q.i2c_sr[1] == q.stb.dc);

	////////////////////////////////////////////////////////////////////////
	// next state

	always_comb begin
		n = q;
		n.s1 = pins_raw;
		n.s2 = q.s1;
		n.s3 = q.s2;
		// a bit moves once the second and third stages agree
		n.stb = dhi_pkg::dhi_pins_t'((q.s2 & q.s3) | (q.stb & (q.s2 | q.s3)));
		n.prv = q.stb;
		n.wr_valid = 1'b0;
		n.rd_req = 1'b0;

		// straps are static; unknown codes leave the port dead
		unique case (q.stb.sel)
			`DHI_SEL_SPI4: n.mode = dhi_pkg::MODE_SPI4;
			`DHI_SEL_SPI3: n.mode = dhi_pkg::MODE_SPI3;
			`DHI_SEL_I2C: n.mode = dhi_pkg::MODE_I2C;
			`DHI_SEL_P6800: n.mode = dhi_pkg::MODE_P6800;
			`DHI_SEL_P8080: n.mode = dhi_pkg::MODE_P8080;
			default: n.mode = dhi_pkg::MODE_OFF;
		endcase

		unique case (q.mode)
			dhi_pkg::MODE_P6800: begin
				// strobe acts only with chip select low
				if (en_fall && !q.stb.cs_n) begin
					if (!q.stb.rw) begin
						n.wr_valid = 1'b1;
						n.wr = '{is_data: q.stb.dc, byte_v: q.stb.d};
					end else begin
						n.rd_req = 1'b1;
						n.rd_is_data = q.stb.dc;
					end
				end
			end
			dhi_pkg::MODE_P8080: begin
				if (rw_rise && !q.stb.cs_n && q.stb.en) begin
					n.wr_valid = 1'b1;
					n.wr = '{is_data: q.stb.dc, byte_v: q.stb.d};
				end else if (en_rise && !q.stb.cs_n && q.stb.rw) begin
					n.rd_req = 1'b1;
					n.rd_is_data = q.stb.dc;
				end
			end
			dhi_pkg::MODE_SPI4, dhi_pkg::MODE_SPI3: begin
				// byte is stable in the receiver until the next one completes
				if (spi_evt) begin
					n.wr_valid = 1'b1;
					n.wr = '{is_data: spi_dc, byte_v: spi_byte};
				end
			end
			dhi_pkg::MODE_I2C: begin
				if (i2c_start) begin
					n.i2c_st = dhi_pkg::I2C_ADDR;
					n.bitcnt = 4'h0;
					n.in_ack = 1'b0;
					n.ack_drv = 1'b0;
				end else if (i2c_stop) begin
					n.i2c_st = dhi_pkg::I2C_IDLE;
					n.in_ack = 1'b0;
					n.ack_drv = 1'b0;
				end else if (q.i2c_st != dhi_pkg::I2C_IDLE) begin
					if (scl_rise && q.bitcnt != `DHI_I2C_ACK_CNT) begin
						n.i2c_sr = {q.i2c_sr[6:0], sda};
						n.bitcnt = q.bitcnt + 4'h1;
					end else if (scl_fall && q.in_ack) begin
						// ninth clock over: release the line
						n.in_ack = 1'b0;
						n.ack_drv = 1'b0;
						n.bitcnt = 4'h0;
					end else if (scl_fall && q.bitcnt == `DHI_I2C_ACK_CNT) begin
						n.in_ack = 1'b1;
						unique case (q.i2c_st)
							dhi_pkg::I2C_ADDR: begin
								if (addr_hit) begin
									n.ack_drv = 1'b1;
									// read mode has nothing to return
									n.i2c_st = q.i2c_sr[0] ? dhi_pkg::I2C_RDIGN
										: dhi_pkg::I2C_CTRL;
								end else begin
									n.i2c_st = dhi_pkg::I2C_IDLE;
								end
							end
							dhi_pkg::I2C_CTRL: begin
								n.cont = q.i2c_sr[7];
								n.dcflag = q.i2c_sr[6];
								n.ack_drv = 1'b1;
								n.i2c_st = dhi_pkg::I2C_DATA;
							end
							dhi_pkg::I2C_DATA: begin
								n.wr_valid = 1'b1;
								n.wr = '{is_data: q.dcflag, byte_v: q.i2c_sr};
								if (q.dcflag) begin
									n.col = q.col + 1'b1;
								end
								n.ack_drv = 1'b1;
								if (q.cont) begin
									n.i2c_st = dhi_pkg::I2C_CTRL;
								end
							end
							dhi_pkg::I2C_RDIGN: ;
							default: n.i2c_st = dhi_pkg::I2C_IDLE;
						endcase
					end
				end
			end
			default: ;
		endcase

		// the core answers a fetch in the cycle of rd_req; the bus shows the older byte
		if (q.rd_req && q.rd_is_data) begin
			n.rd_hold = rd_data;
		end

		// pad drive: parallel reads and the i2c acknowledge bit; spi modes never drive
		n.doe = 8'h00;
		n.dout = q.dout;
		if (!q.stb.cs_n && ((q.mode == dhi_pkg::MODE_P6800 && q.stb.rw && q.stb.en)
			|| (q.mode == dhi_pkg::MODE_P8080 && q.stb.rw && !q.stb.en))) begin
			n.doe = 8'hff;
			n.dout = q.stb.dc ? q.rd_hold : status_in;
		end else if (q.mode == dhi_pkg::MODE_I2C) begin
			// if the drive pad is unconnected the host ignores this
			n.doe[`DHI_SDA_OUT_BIT] = q.ack_drv;
			n.dout = 8'h00;
		end

		// hardware reset clears the port but lets the synchroniser run
		if (!q.stb.hw_rst_n) begin
			n.i2c_st = dhi_pkg::I2C_IDLE;
			n.i2c_sr = 8'h00;
			n.bitcnt = 4'h0;
			n.in_ack = 1'b0;
			n.ack_drv = 1'b0;
			n.cont = 1'b0;
			n.dcflag = 1'b0;
			n.wr_valid = 1'b0;
			n.rd_req = 1'b0;
			n.rd_hold = 8'h00;
			n.doe = 8'h00;
			n.col = COL_W'(`DHI_COL_RST);
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			q <= '0;
			q.s1 <= `DHI_PIN_RST;
			q.s2 <= `DHI_PIN_RST;
			q.s3 <= `DHI_PIN_RST;
			q.stb <= `DHI_PIN_RST;
			q.prv <= `DHI_PIN_RST;
			q.mode <= dhi_pkg::MODE_OFF;
			q.col <= COL_W'(`DHI_COL_RST);
		end else begin
			q <= n;
		end
	end

	assign data_out = q.dout;
	assign data_oe = q.doe;
	assign wr_valid = q.wr_valid;
	assign wr = q.wr;
	assign rd_req = q.rd_req;
	assign rd_is_data = q.rd_is_data;
	assign col_addr = q.col;
	assign mode = q.mode;

	////////////////////////////////////////////////////////////////////////
	// checks

	a_sel_to_mode: assert property (@(posedge clk) disable iff (srst)
		q.stb.sel == `DHI_SEL_I2C |=> q.mode == dhi_pkg::MODE_I2C)
		else $error("i2c select did not give i2c mode");

	a_e_fall_write: assert property (@(posedge clk) disable iff (srst)
		q.mode == dhi_pkg::MODE_P6800 && en_fall && !q.stb.cs_n && !q.stb.rw
		&& q.stb.hw_rst_n |=> q.wr_valid && q.wr.byte_v == $past(q.stb.d)
		&& q.wr.is_data == $past(q.stb.dc))
		else $error("enable fall write not captured");

	a_cs_high_quiet: assert property (@(posedge clk) disable iff (srst)
		q.mode == dhi_pkg::MODE_P6800 && q.stb.cs_n |=> !q.wr_valid && !q.rd_req)
		else $error("parallel access while deselected");

	a_wr_rise_latch: assert property (@(posedge clk) disable iff (srst)
		q.mode == dhi_pkg::MODE_P8080 && rw_rise && !q.stb.cs_n && q.stb.en
		&& q.stb.hw_rst_n |=> q.wr_valid && q.wr.byte_v == $past(q.stb.d))
		else $error("write strobe rise not latched");

	a_rd_rise_done: assert property (@(posedge clk) disable iff (srst)
		q.mode == dhi_pkg::MODE_P8080 && en_rise && !rw_rise && !q.stb.cs_n
		&& q.stb.rw && q.stb.hw_rst_n |=> q.rd_req && q.rd_is_data == $past(q.stb.dc))
		else $error("read strobe rise not completed");

	a_spi_route: assert property (@(posedge clk) disable iff (srst)
		(q.mode == dhi_pkg::MODE_SPI4 || q.mode == dhi_pkg::MODE_SPI3) && spi_evt
		&& q.stb.hw_rst_n |=> q.wr_valid && q.wr.is_data == $past(spi_dc))
		else $error("serial byte not routed");

	a_spi_no_drive: assert property (@(posedge clk) disable iff (srst)
		q.mode == dhi_pkg::MODE_SPI4 ##1 q.mode == dhi_pkg::MODE_SPI4 |-> q.doe == 8'h00)
		else $error("pads driven in serial mode");

	a_i2c_start_addr: assert property (@(posedge clk) disable iff (srst)
		q.mode == dhi_pkg::MODE_I2C && i2c_start && q.stb.hw_rst_n
		|=> q.i2c_st == dhi_pkg::I2C_ADDR && q.bitcnt == 4'h0)
		else $error("start did not open address phase");

	a_i2c_stop_idle: assert property (@(posedge clk) disable iff (srst)
		q.mode == dhi_pkg::MODE_I2C && i2c_stop |=> q.i2c_st == dhi_pkg::I2C_IDLE)
		else $error("stop did not end transaction");

	a_i2c_ack_pad: assert property (@(posedge clk) disable iff (srst)
		q.mode == dhi_pkg::MODE_I2C && $rose(q.ack_drv) && q.stb.hw_rst_n
		|=> q.doe[`DHI_SDA_OUT_BIT] && !q.dout[`DHI_SDA_OUT_BIT])
		else $error("acknowledge not driven low");

	a_i2c_col_step: assert property (@(posedge clk) disable iff (srst)
		q.mode == dhi_pkg::MODE_I2C && q.wr_valid && q.wr.is_data
		&& $past(q.stb.hw_rst_n) |-> q.col == $past(q.col) + 1'b1)
		else $error("column pointer did not step");

endmodule

`default_nettype wire

// ===== testbench.sv
`timescale 1ns/1ps
`default_nettype none

module testbench;

	logic clk, srst, hardware_reset_n, cs_n, dc, rw, en, sda;
	logic wr_valid, rd_req, rd_is_data;
	logic [2:0] sel;
	logic [7:0] hd, din, dout, oe, col, rb;
	dhi_pkg::dhi_wr_t wr;
	dhi_pkg::dhi_mode_t mode;
	dhi_pkg::dhi_wr_t wq[$];
	logic rq[$];
	logic [2:0] exp_m [8] = '{3'h0, 3'h1, 3'h2, 3'h7, 3'h4, 3'h7, 3'h6, 3'h7};
	int num_errors, n_compared, cyc;

	// pads: i2c ties d1 and d2 with a pull-up, otherwise the driver wins per bit
	assign sda = hd[1] & ~(oe[2] & ~dout[2]);
	assign din = (sel == 3'h2) ? {hd[7:3], sda, sda, hd[0]} : (oe & dout) | (~oe & hd);

	dhi_host i_host (.clk(clk), .bus(din), .cs_n(cs_n), .dc(dc), .rw(rw), .en(en), .d(hd));

	dhi_top i_dut (.clk(clk), .srst(srst), .hardware_reset_n(hardware_reset_n),
		.interface_select_pins(sel), .cs_n(cs_n), .dc_sel(dc), .rw_sel(rw), .en_sel(en),
		.data_in(din), .spi_sclk(din[0]), .data_out(dout), .data_oe(oe),
		.status_in(8'h3c), .rd_data(8'ha5), .wr_valid(wr_valid), .wr(wr),
		.rd_req(rd_req), .rd_is_data(rd_is_data), .col_addr(col), .mode(mode));

	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	// collect pulses; also cut a hang short
	always @(posedge clk) begin
		if (wr_valid === 1'b1) wq.push_back(wr);
		if (rd_req === 1'b1) rq.push_back(rd_is_data);
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			num_errors++;
			summarize();
		end
	end

	////////////////////////////////////////
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		n_compared++;
		if (got !== exp) begin
			num_errors++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic chk_wr(input dhi_pkg::dhi_wr_t e);
		dhi_pkg::dhi_wr_t g;
		g = 'x;
		repeat (40) if (wq.size() == 0) @(posedge clk);
		if (wq.size() > 0) g = wq.pop_front();
		chk({7'h0, g}, {7'h0, e});
	endtask

	task automatic chk_rd(input logic e);
		logic g;
		g = 1'bx;
		repeat (20) @(posedge clk);
		if (rq.size() > 0) g = rq.pop_front();
		chk({15'h0, g}, {15'h0, e});
	endtask

	// a refused access must leave no byte behind
	task automatic none();
		repeat (20) @(posedge clk);
		chk(16'(wq.size()), 16'h0000);
	endtask

	// strap change is made inside a reset, with the host pins parked for the new port
	task automatic set_mode(input logic [2:0] m);
		@(posedge clk);
		srst <= 1'b1;
		sel <= m;
		i_host.park(m);
		repeat (10) @(posedge clk);
		srst <= 1'b0;
		repeat (12) @(posedge clk);
	endtask

	task automatic i2c_tx(input int n, input logic [39:0] v, input logic ak);
		logic a;
		i_host.i2c_ss(1'b1);
		for (int i = n - 1; i >= 0; i--) begin
			i_host.i2c_byte(v[i*8 +: 8], a);
			chk({15'h0, a}, {15'h0, ak});
		end
		i_host.i2c_ss(1'b0);
	endtask

	task automatic summarize();
		$display("compared %0d mismatches %0d", n_compared, num_errors);
		if (num_errors == 0 && n_compared > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask

	////////////////////////////////////////
	initial begin
		srst = 1'b1;
		hardware_reset_n = 1'b1;
		sel = 3'h7;
		num_errors = 0;
		n_compared = 0;
		cyc = 0;
		for (int k = 0; k < 8; k++) begin
			set_mode(3'(k));
			chk({13'h0, mode}, {13'h0, exp_m[k]});
		end
		$display("test decode done");
		// both parallel ports: writes, a deselected strobe, dummy then real reads
		for (int k = 4; k <= 6; k += 2) begin
			set_mode(3'(k));
			i_host.par(k, 0, 0, 0, 8'h3a, rb);
			chk_wr(9'h03a);
			i_host.par(k, 0, 0, 1, 8'hc5, rb);
			chk_wr(9'h1c5);
			i_host.par(k, 1, 0, 1, 8'h66, rb);
			none();
			i_host.par(k, 0, 1, 1, 8'h00, rb);
			chk({8'h0, rb}, 16'h0000);
			chk_rd(1'b1);
			i_host.par(k, 0, 1, 1, 8'h00, rb);
			chk({8'h0, rb}, 16'h00a5);
			chk_rd(1'b1);
			i_host.par(k, 0, 1, 0, 8'h00, rb);
			chk({8'h0, rb}, 16'h003c);
			chk_rd(1'b0);
			$display("test parallel %0d done", k);
		end
		set_mode(3'h0);
		i_host.spi(8, 0, 9'h081);
		chk_wr(9'h081);
		i_host.spi(8, 1, 9'h07e);
		chk_wr(9'h17e);
		i_host.spi(5, 1, 9'h01f);
		none();
		i_host.spi(8, 1, 9'h0f0);
		chk_wr(9'h1f0);
		chk({8'h0, oe}, 16'h0000);
		set_mode(3'h1);
		i_host.spi(9, 0, 9'h1a5);
		chk_wr(9'h1a5);
		i_host.spi(9, 0, 9'h03c);
		chk_wr(9'h03c);
		$display("test serial done");
		// address lsb pin is high in this mode, so 0111101 is ours
		set_mode(3'h2);
		i2c_tx(4, 40'h007a401122, 1'b1);
		chk_wr(9'h111);
		chk_wr(9'h122);
		chk({8'h0, col}, 16'h0002);
		i2c_tx(5, 40'h7a80aec055, 1'b1);
		chk_wr(9'h0ae);
		chk_wr(9'h155);
		chk({8'h0, col}, 16'h0003);
		i2c_tx(1, 40'h0000000078, 1'b0);
		none();
		i2c_tx(1, 40'h000000007b, 1'b1);
		none();
		@(posedge clk);
		hardware_reset_n <= 1'b0;
		repeat (8) @(posedge clk);
		hardware_reset_n <= 1'b1;
		repeat (8) @(posedge clk);
		chk({8'h0, col}, 16'h0000);
		$display("test i2c done");
		summarize();
	end

endmodule

`default_nettype wire
